// >>> design/port_wake_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module port_wake_ctrl
#(
   parameter int HOLD_CYCLES = port_wake_pkg::WARM_HOLD_CYCLES
)
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // special register port
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   input  wire logic        sfr_we_i,
   input  wire logic        sfr_re_i,
   input  wire logic        rmw_i,
   output logic      [7:0]  sfr_rdata_o,
   // core interface
   input  wire logic        instr_done_i,
   input  wire logic [7:0]  periph_irq_i,
   output logic             irq_ext0_o,
   output logic             irq_ext1_o,
   output logic             irq_pin_change_o,
   output logic             irq_low_voltage_o,
   output logic             irq_periph_o,
   output logic             cpu_hold_o,
   output logic             osc_stop_o,
   // low-voltage detector
   input  wire logic        low_voltage_flag_i,
   output logic      [3:0]  lvd_select_o,
   output logic             low_voltage_detector_powerdown_o,
   // pins
   input  wire logic [31:0] pin_i,
   input  wire logic [31:0] alt_out_i,
   output logic      [31:0] pin_o,
   output logic      [31:0] pin_oe_o,
   output logic      [31:0] pull_up_o,
   output logic      [31:0] pull_dn_o,
   output logic      [31:0] analog_en_o,
   output logic      [31:0] led_en_o,
   output logic      [31:0] lcd_bias_o
);
   initial
   begin
      if (HOLD_CYCLES < 1 || HOLD_CYCLES > 15)
         $error("HOLD_CYCLES must lie in 1..15");
   end

   localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYCLES - 1);

   typedef struct packed {
      logic [31:0]           sync1;
      logic [31:0]           sync2;
      logic [31:0]           prev;
      logic                  lvd_s1;
      logic                  lvd_s2;
      logic                  ea;
      logic                  ex0;
      logic                  ex1;
      logic                  low_voltage_irq_enable;
      logic                  pcie;
      logic                  pcflag;
      logic                  smod;
      logic [1:0]            gf;
      logic                  lvd_pd;
      logic [3:0]            lvd_sel;
      logic [1:0]            pidx;
      logic [31:0]           latch;
      logic [127:0]          mode;
      port_wake_pkg::pwr_type pst;
      logic [3:0]            cnt;
      logic [7:0]            rdata;
   } state_type;

   state_type s;
   state_type next_s;

   // {out, oe, pull-up, pull-down, analog, led, lcd}
   function automatic logic [6:0] pin_drive(input logic [3:0] m,
                                           input logic d,
                                           input logic a);
      logic [6:0] r;
      r = 7'h00;
      if (!m[1])
         // open drain: latch 1 releases the pin
         r = {1'b0, ~d, d & (m[2:0] == 3'b000),
              d & (m[2:0] == 3'b100), 3'b000};
      else if (!m[0])
         r = {d, 1'b1, 5'b00000};
      else
         case (m[3:2])
            2'b00:   r = 7'b0000100;
            2'b01:   r = 7'b0000010;
            2'b10:   r = {a, 1'b1, 5'b00000};
            default: r = 7'b0011001;
         endcase
      return r;
   endfunction

   logic [31:0] pc_mode;
   logic [31:0] pin_chg;
   logic        ext0_act;
   logic        ext1_act;
   logic        irq_mask;
   logic        idle_wake;
   logic        halt_wake;
   logic [7:0]  rd;

   always_comb
   begin
      for (int i = 0; i < 32; i++)
         pc_mode[i] = s.mode[4*i+3] & ~s.mode[4*i+1];
   end

   // pin change only in wake modes
   assign pin_chg  = (s.sync2 ^ s.prev) & pc_mode
                   & port_wake_pkg::PIN_PRESENT;
   // external pins are low-level triggers in open-drain modes
   assign ext0_act = ~s.sync2[port_wake_pkg::EXT0_PIN]
                   & ~s.mode[4*port_wake_pkg::EXT0_PIN+1];
   assign ext1_act = ~s.sync2[port_wake_pkg::EXT1_PIN]
                   & ~s.mode[4*port_wake_pkg::EXT1_PIN+1];
   // after a halt wake, no interrupt until the next instruction retires
   assign irq_mask = (s.pst == port_wake_pkg::PWR_HALT)
                   | (s.pst == port_wake_pkg::PWR_WARM)
                   | (s.pst == port_wake_pkg::PWR_POST);

   // own enable and global both needed; peripheral requests need only the global
   assign idle_wake = s.ea & ((s.ex0 & ext0_act) | (s.ex1 & ext1_act)
                    | (s.pcie & s.pcflag)
                    | (s.low_voltage_irq_enable & s.lvd_s2) | (|periph_irq_i));
   // halt wake ignores the global enable
   // pin change wakes regardless of its irq enable
   assign halt_wake = (s.ex0 & ext0_act) | (s.ex1 & ext1_act)
                    | (|pin_chg);

   // level must still stand once the mask lifts
   assign irq_ext0_o        = s.ea & s.ex0 & ext0_act & ~irq_mask;
   assign irq_ext1_o        = s.ea & s.ex1 & ext1_act & ~irq_mask;
   assign irq_pin_change_o  = s.ea & s.pcie & s.pcflag & ~irq_mask;
   assign irq_low_voltage_o = s.ea & s.low_voltage_irq_enable & s.lvd_s2 & ~irq_mask;
   assign irq_periph_o      = s.ea & (|periph_irq_i) & ~irq_mask;
   assign cpu_hold_o        = (s.pst == port_wake_pkg::PWR_IDLE)
                            | (s.pst == port_wake_pkg::PWR_HALT)
                            | (s.pst == port_wake_pkg::PWR_WARM);
   assign osc_stop_o        = (s.pst == port_wake_pkg::PWR_HALT);
   assign sfr_rdata_o       = s.rdata;
   assign lvd_select_o      = s.lvd_sel;
   assign low_voltage_detector_powerdown_o = s.lvd_pd;

   always_comb
   begin
      logic [6:0] dv;
      dv = 7'h00;
      for (int i = 0; i < 32; i++)
      begin
         dv = pin_drive(s.mode[4*i +: 4], s.latch[i], alt_out_i[i]);
         if (!port_wake_pkg::PIN_PRESENT[i])
            dv = 7'h00;
         pin_o[i]       = dv[6];
         pin_oe_o[i]    = dv[5];
         pull_up_o[i]   = dv[4];
         pull_dn_o[i]   = dv[3];
         analog_en_o[i] = dv[2];
         led_en_o[i]    = dv[1];
         lcd_bias_o[i]  = dv[0];
      end
   end

   always_comb
   begin
      rd = 8'h00;
      case (sfr_addr_i)
         port_wake_pkg::ADDR_POWER_CONTROL:
            rd = {s.smod, 3'b000, s.gf,
                  (s.pst == port_wake_pkg::PWR_HALT)
                  | (s.pst == port_wake_pkg::PWR_WARM),
                  (s.pst == port_wake_pkg::PWR_IDLE)};
         port_wake_pkg::ADDR_IRQ_ENABLE:
            rd = {s.ea, 4'b0000, s.ex1, 1'b0, s.ex0};
         port_wake_pkg::ADDR_IRQ_ENABLE2:
            rd = {5'b00000, s.low_voltage_irq_enable, s.pcie, s.pcflag};
         port_wake_pkg::ADDR_LOW_VOLTAGE:
            rd = {s.lvd_pd, s.lvd_s2, 2'b00, s.lvd_sel};
         port_wake_pkg::ADDR_PORT_INDEX:
            rd = {6'b000000, s.pidx};
         port_wake_pkg::ADDR_PORT0:
            rd = rmw_i ? s.latch[7:0] : s.sync2[7:0];
         port_wake_pkg::ADDR_PORT1:
            rd = rmw_i ? s.latch[15:8] : s.sync2[15:8];
         port_wake_pkg::ADDR_PORT2:
            rd = (rmw_i ? s.latch[23:16] : s.sync2[23:16])
               & port_wake_pkg::PIN_PRESENT[23:16];
         port_wake_pkg::ADDR_PORT3:
            rd = rmw_i ? s.latch[31:24] : s.sync2[31:24];
         default:
         begin
            // pair registers follow the port index
            if (sfr_addr_i[7:2] == port_wake_pkg::ADDR_PAIR_MODE_A[7:2])
               rd = s.mode[32*s.pidx + 8*sfr_addr_i[1:0] +: 8];
         end
      endcase
   end

   always_comb
   begin
      next_s = s;
      // two-flop synchronisers on pins and detector
      next_s.sync1  = pin_i;
      next_s.sync2  = s.sync1;
      next_s.prev   = s.sync2;
      next_s.lvd_s1 = low_voltage_flag_i;
      next_s.lvd_s2 = s.lvd_s1;
      if (sfr_re_i)
         next_s.rdata = rd;
      if (sfr_we_i)
      begin
         case (sfr_addr_i)
            port_wake_pkg::ADDR_POWER_CONTROL:
            begin
               next_s.smod = sfr_wdata_i[port_wake_pkg::POWER_CONTROL_SMOD];
               next_s.gf   = {sfr_wdata_i[port_wake_pkg::POWER_CONTROL_GF1],
                              sfr_wdata_i[port_wake_pkg::POWER_CONTROL_GF0]};
            end
            port_wake_pkg::ADDR_IRQ_ENABLE:
            begin
               next_s.ea  = sfr_wdata_i[port_wake_pkg::IE_GLOBAL];
               next_s.ex1 = sfr_wdata_i[port_wake_pkg::IE_EXT1];
               next_s.ex0 = sfr_wdata_i[port_wake_pkg::IE_EXT0];
            end
            port_wake_pkg::ADDR_IRQ_ENABLE2:
            begin
               next_s.low_voltage_irq_enable  = sfr_wdata_i[port_wake_pkg::IE2_LVD];
               next_s.pcie   = sfr_wdata_i[port_wake_pkg::IE2_PCHG];
               // writing 0 clears, writing 1 leaves it
               next_s.pcflag = s.pcflag
                             & sfr_wdata_i[port_wake_pkg::IE2_PFLAG];
            end
            port_wake_pkg::ADDR_LOW_VOLTAGE:
            begin
               next_s.lvd_pd  = sfr_wdata_i[port_wake_pkg::LV_PD];
               next_s.lvd_sel = sfr_wdata_i[3:0];
            end
            port_wake_pkg::ADDR_PORT_INDEX:
               next_s.pidx = sfr_wdata_i[1:0];
            port_wake_pkg::ADDR_PORT0:
               next_s.latch[7:0] = sfr_wdata_i;
            port_wake_pkg::ADDR_PORT1:
               next_s.latch[15:8] = sfr_wdata_i;
            port_wake_pkg::ADDR_PORT2:
               next_s.latch[23:16] = sfr_wdata_i;
            port_wake_pkg::ADDR_PORT3:
               next_s.latch[31:24] = sfr_wdata_i;
            default:
            begin
               // high nibble lands on the odd pin
               if (sfr_addr_i[7:2] ==
                   port_wake_pkg::ADDR_PAIR_MODE_A[7:2])
                  next_s.mode[32*s.pidx + 8*sfr_addr_i[1:0] +: 8]
                     = sfr_wdata_i;
            end
         endcase
      end
      // set wins over a clear in the same cycle
      if (|pin_chg)
         next_s.pcflag = 1'b1;
      case (s.pst)
         port_wake_pkg::PWR_RUN,
         port_wake_pkg::PWR_POST:
         begin
            if (s.pst == port_wake_pkg::PWR_POST && instr_done_i)
               next_s.pst = port_wake_pkg::PWR_RUN;
            if (sfr_we_i &&
                sfr_addr_i == port_wake_pkg::ADDR_POWER_CONTROL)
            begin
               if (sfr_wdata_i[port_wake_pkg::POWER_CONTROL_HALT])
                  next_s.pst = port_wake_pkg::PWR_HALT;
               else if (sfr_wdata_i[port_wake_pkg::POWER_CONTROL_IDLE])
                  next_s.pst = port_wake_pkg::PWR_IDLE;
            end
         end
         // irq outputs are live as idle ends
         port_wake_pkg::PWR_IDLE:
            if (idle_wake)
               next_s.pst = port_wake_pkg::PWR_RUN;
         port_wake_pkg::PWR_HALT:
            if (halt_wake)
            begin
               next_s.pst = port_wake_pkg::PWR_WARM;
               next_s.cnt = 4'h0;
            end
         // hold covers oscillator warm-up; slot one runs after it
         port_wake_pkg::PWR_WARM:
         begin
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == HOLD_LAST)
               next_s.pst = port_wake_pkg::PWR_POST;
         end
         default:
            next_s.pst = port_wake_pkg::PWR_RUN;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         s       <= '0;
         // every pin starts in code 0001
         s.mode  <= {16{port_wake_pkg::PAIR_RESET}};
         s.pst   <= port_wake_pkg::PWR_RUN;
         s.rdata <= port_wake_pkg::REG_RESET;
      end
      else
         s <= next_s;
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_power_control_write(int b);
      sfr_we_i && sfr_addr_i == port_wake_pkg::ADDR_POWER_CONTROL
      && sfr_wdata_i[b] && s.pst == port_wake_pkg::PWR_RUN;
   endsequence
   sequence s_halt_wake;
      s.pst == port_wake_pkg::PWR_HALT ##1
      s.pst == port_wake_pkg::PWR_WARM;
   endsequence

   a_halt_entry: assert property (
      s_power_control_write(port_wake_pkg::POWER_CONTROL_HALT) |=> osc_stop_o && cpu_hold_o)
      else $error("halt request not taken");
   a_idle_entry: assert property (
      s_power_control_write(port_wake_pkg::POWER_CONTROL_IDLE)
      && !sfr_wdata_i[port_wake_pkg::POWER_CONTROL_HALT]
      |=> cpu_hold_o && !osc_stop_o)
      else $error("idle request not taken");
   a_idle_needs_ea: assert property (
      s.pst == port_wake_pkg::PWR_IDLE && !s.ea && !sfr_we_i
      |=> s.pst == port_wake_pkg::PWR_IDLE)
      else $error("idle left without global enable");
   a_idle_irq_now: assert property (
      s.pst == port_wake_pkg::PWR_IDLE && irq_ext0_o
      |=> !cpu_hold_o && irq_ext0_o)
      else $error("idle wake did not enter service");
   a_halt_no_ea: assert property (
      s.pst == port_wake_pkg::PWR_HALT && !s.ea
      && ((s.ex0 && ext0_act) || (s.ex1 && ext1_act))
      |=> s.pst == port_wake_pkg::PWR_WARM)
      else $error("pin enable alone did not wake");
   a_halt_order: assert property (
      s.pst == port_wake_pkg::PWR_POST
      |-> !irq_ext0_o && !irq_ext1_o && !irq_pin_change_o
      && !irq_low_voltage_o && !irq_periph_o && !cpu_hold_o)
      else $error("interrupt before post-halt slot");
   a_warm_bound: assert property (
      s_halt_wake |-> ##[1:15] s.pst == port_wake_pkg::PWR_POST)
      else $error("warm hold too long");
   a_pc_gate: assert property (
      !s.pcie |-> !irq_pin_change_o)
      else $error("pin change irq leaked");
   a_pc_wake: assert property (
      s.pst == port_wake_pkg::PWR_HALT && (|pin_chg) && !s.pcie
      |=> s.pst == port_wake_pkg::PWR_WARM)
      else $error("pin change did not wake");
   a_lvd_gate: assert property (
      irq_low_voltage_o |-> s.low_voltage_irq_enable && $past(low_voltage_flag_i, 2))
      else $error("detector irq without enable");
   a_rmw_latch: assert property (
      sfr_re_i && rmw_i && sfr_addr_i == port_wake_pkg::ADDR_PORT1
      |=> sfr_rdata_o == $past(s.latch[15:8]))
      else $error("rmw read did not see latch");
   a_mode_reset: assert property (
      $past(rst_i) |-> s.mode[7:0] == port_wake_pkg::PAIR_RESET)
      else $error("pair register reset wrong");
endmodule
`default_nettype wire

// >>> inc/port_wake_pkg.sv
package port_wake_pkg;
   // register addresses
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'hA8;
   localparam logic [7:0] ADDR_IRQ_ENABLE2   = 8'hA9;
   localparam logic [7:0] ADDR_LOW_VOLTAGE   = 8'hBF;
   localparam logic [7:0] ADDR_PORT_INDEX    = 8'hF3;
   localparam logic [7:0] ADDR_PAIR_MODE_A   = 8'hF4;
   localparam logic [7:0] ADDR_PORT0         = 8'h80;
   localparam logic [7:0] ADDR_PORT1         = 8'h90;
   localparam logic [7:0] ADDR_PORT2         = 8'hA0;
   localparam logic [7:0] ADDR_PORT3         = 8'hB0;
   // field positions
   localparam int POWER_CONTROL_SMOD   = 7;
   localparam int POWER_CONTROL_GF1    = 3;
   localparam int POWER_CONTROL_GF0    = 2;
   localparam int POWER_CONTROL_HALT   = 1;
   localparam int POWER_CONTROL_IDLE   = 0;
   localparam int IE_GLOBAL   = 7;
   localparam int IE_EXT1     = 2;
   localparam int IE_EXT0     = 0;
   localparam int IE2_LVD     = 2;
   localparam int IE2_PCHG    = 1;
   localparam int IE2_PFLAG   = 0;
   localparam int LV_PD       = 7;
   localparam int LV_FLAG     = 6;
   // pins and reset values
   localparam int EXT0_PIN    = 26;
   localparam int EXT1_PIN    = 27;
   localparam logic [31:0] PIN_PRESENT = 32'hFF3F_FFFF;
   localparam logic [7:0]  PAIR_RESET  = 8'h11;
   localparam logic [7:0]  REG_RESET   = 8'h00;
   // timing
   localparam int WARM_HOLD_CYCLES = 2;
   typedef enum logic [2:0]
   {
      PWR_RUN,
      PWR_IDLE,
      PWR_HALT,
      PWR_WARM,
      PWR_POST
   } pwr_type;
endpackage

// >>> dv/port_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module port_pin_model
(
   // clock
   input  wire logic        core_clk_i,
   // design pin side
   input  wire logic [31:0] pin_o,
   input  wire logic [31:0] pin_oe_o,
   input  wire logic [31:0] pull_up_o,
   input  wire logic [31:0] pull_dn_o,
   // external drivers
   input  wire logic [31:0] ext_en_i,
   input  wire logic [31:0] ext_val_i,
   output logic      [31:0] level_o
);
   logic [31:0] last = 32'h0000_0000;
   // pin level resolve
   // an undriven line flips each cycle, so a stale level never looks driven
   always_comb
   begin
      for (int i = 0; i < 32; i++)
      begin
         if (pin_oe_o[i] === 1'b1)
            level_o[i] = pin_o[i];
         else if (ext_en_i[i])
            level_o[i] = ext_val_i[i];
         else if (pull_up_o[i] === 1'b1)
            level_o[i] = 1'b1;
         else if (pull_dn_o[i] === 1'b1)
            level_o[i] = 1'b0;
         else
            level_o[i] = ~last[i];
      end
   end
   always_ff @(posedge core_clk_i)
      last <= level_o;
endmodule
`default_nettype wire

// >>> dv/port_mode_and_wake_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module port_mode_and_wake_control_tb_top;
   localparam int HOLD = 2;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic        sfr_we_i = 1'b0, sfr_re_i = 1'b0, rmw_i = 1'b0;
   logic        instr_done_i = 1'b0, low_voltage_flag_i = 1'b0;
   logic [7:0]  periph_irq_i = 8'h00;
   logic [3:0]  lvd_select_o;
   logic        irq_ext0_o, irq_ext1_o, irq_pin_change_o, irq_low_voltage_o;
   logic        irq_periph_o, cpu_hold_o, osc_stop_o;
   logic        low_voltage_detector_powerdown_o;
   logic [31:0] pin_i, pin_o, pin_oe_o, pull_up_o, pull_dn_o;
   logic [31:0] analog_en_o, led_en_o, lcd_bias_o;
   logic [31:0] alt_out_i = 32'h0000_0000;
   logic [31:0] ext_en = 32'hFFFF_FFFF, ext_val = 32'hFFFF_FFFF;
   int          mismatches = 0, comparisons = 0, seed = 30439;
   logic [3:0]  mode_m [32];
   logic        latch_m [32];

   port_wake_ctrl #(.HOLD_CYCLES(HOLD)) i_port_wake_ctrl
   (
      .core_clk_i, .rst_i, .sfr_addr_i, .sfr_wdata_i, .sfr_we_i, .sfr_re_i,
      .rmw_i, .sfr_rdata_o, .instr_done_i, .periph_irq_i, .irq_ext0_o,
      .irq_ext1_o, .irq_pin_change_o, .irq_low_voltage_o, .irq_periph_o,
      .cpu_hold_o, .osc_stop_o, .low_voltage_flag_i, .lvd_select_o,
      .low_voltage_detector_powerdown_o, .pin_i, .alt_out_i, .pin_o,
      .pin_oe_o, .pull_up_o, .pull_dn_o, .analog_en_o, .led_en_o, .lcd_bias_o
   );
   port_pin_model i_port_pin_model
   (
      .core_clk_i, .pin_o, .pin_oe_o, .pull_up_o, .pull_dn_o,
      .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i)
   );

   initial forever #2.5 core_clk_i = ~core_clk_i;

   task automatic check(input string w, input logic [31:0] s, e);
      comparisons++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, d,
                      input logic m, output logic [7:0] q);
      @(posedge core_clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_we_i <= w;
      sfr_re_i <= ~w;
      rmw_i <= m;
      @(posedge core_clk_i);
      sfr_we_i <= 1'b0;
      sfr_re_i <= 1'b0;
      #1 q = sfr_rdata_o;
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      bus(1'b1, a, d, 1'b0, q);
   endtask
   task automatic rdchk(input string w, input logic [7:0] a, input logic m,
                        input logic [7:0] e, input logic [7:0] mk = 8'hFF);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, m, q);
      check(w, 32'(q & mk), 32'(e & mk));
   endtask
   function automatic logic sig(input int s);
      return (s == 0) ? cpu_hold_o : (s == 1) ? osc_stop_o : irq_ext1_o;
   endfunction
   task automatic wait_sig(input string w, input int s, input logic v, int n);
      for (int i = 0; i < n && sig(s) !== v; i++)
      begin
         @(posedge core_clk_i);
         #1;
      end
      check(w, 32'(sig(s)), 32'(v));
   endtask
   task automatic stay(input string w, input int s, input logic v, int n);
      repeat (n)
      begin
         @(posedge core_clk_i);
         #1 check(w, 32'(sig(s)), 32'(v));
      end
   endtask
   task automatic pin(input int i, input logic v);
      @(posedge core_clk_i);
      ext_val[i] <= v;
   endtask
   task automatic retire;
      @(posedge core_clk_i);
      instr_done_i <= 1'b1;
      @(posedge core_clk_i);
      instr_done_i <= 1'b0;
      #1;
   endtask
   task automatic modes(input logic rnd);
      logic [7:0] v;
      for (int p = 0; p < 4; p++)
      begin
         wr(port_wake_pkg::ADDR_PORT_INDEX, 8'(p));
         for (int k = 0; k < 4; k++)
         begin
            v = rnd ? 8'($random(seed)) : port_wake_pkg::PAIR_RESET;
            {mode_m[8*p+2*k+1], mode_m[8*p+2*k]} = v;
            wr(port_wake_pkg::ADDR_PAIR_MODE_A + 8'(k), v);
         end
         v = rnd ? 8'($random(seed)) : 8'hFF;
         for (int b = 0; b < 8; b++)
            latch_m[8*p+b] = v[b];
         wr(port_wake_pkg::ADDR_PORT0 + 8'(16*p), v);
      end
   endtask
   task automatic check_pins;
      logic [31:0] oe, o, pu, pd, an, led, lcd, mk, pr;
      logic [3:0]  m;
      logic        l, od, pp, al;
      pr = port_wake_pkg::PIN_PRESENT;
      for (int i = 0; i < 32; i++)
      begin
         m = mode_m[i];
         l = latch_m[i];
         od = ~m[1];
         pp = m[1:0] == 2'b10;
         al = m == 4'hB;
         mk[i] = od | pp | al | ~pr[i];
         oe[i] = od ? ~l : pp | al;
         o[i] = pp ? l : al & alt_out_i[i];
         pu[i] = od & l & (m[2:0] == 3'b000) | (m == 4'hF);
         pd[i] = od & l & (m[2:0] == 3'b100) | (m == 4'hF);
         an[i] = m == 4'h3;
         led[i] = m == 4'h7;
         lcd[i] = m == 4'hF;
      end
      check("pin_oe_o", pin_oe_o & mk, oe & pr);
      check("pin_o", pin_o & mk, o & pr);
      check("pull_up_o", pull_up_o, pu & pr);
      check("pull_dn_o", pull_dn_o, pd & pr);
      check("analog_en_o", analog_en_o, an & pr);
      check("led_en_o", led_en_o, led & pr);
      check("lcd_bias_o", lcd_bias_o, lcd & pr);
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #250000;
      mismatches++;
      $display("watchdog expired");
      finish_test();
   end

   initial
   begin
      logic [7:0] v;
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      for (int p = 0; p < 4; p++)
      begin
         wr(port_wake_pkg::ADDR_PORT_INDEX, 8'(p));
         for (int k = 0; k < 4; k++)
            rdchk("pair reset", 8'hF4 + 8'(k), 1'b0, 8'h11);
      end
      rdchk("power_control", port_wake_pkg::ADDR_POWER_CONTROL, 0, 8'h00);
      rdchk("irq enable 2", port_wake_pkg::ADDR_IRQ_ENABLE2, 0, 8'h00);
      rdchk("unmapped", 8'h55, 1'b0, 8'h00);
      $display("test reset done");
      for (int c = 0; c < 16; c++)
      begin
         v = {1'($random(seed)), 3'b000, 4'(c)};
         wr(port_wake_pkg::ADDR_LOW_VOLTAGE, v | 8'h40);
         check("lvd_select_o", 32'(lvd_select_o), 32'(c));
         check("lvd pd", 32'(low_voltage_detector_powerdown_o), 32'(v[7]));
         rdchk("low_voltage_select", 8'hBF, 1'b0, v);
      end
      low_voltage_flag_i <= 1'b1;
      wr(port_wake_pkg::ADDR_IRQ_ENABLE, 8'h80);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE2, 8'h04);
      check("lvd irq on", 32'(irq_low_voltage_o), 32'h1);
      rdchk("lvd flag", 8'hBF, 1'b0, v | 8'h40);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE2, 8'h00);
      check("lvd irq off", 32'(irq_low_voltage_o), 32'h0);
      low_voltage_flag_i <= 1'b0;
      $display("test low voltage done");
      alt_out_i <= $random(seed);
      modes(1'b1);
      for (int p = 0; p < 4; p++)
      begin
         wr(port_wake_pkg::ADDR_PORT_INDEX, 8'(p));
         for (int k = 0; k < 4; k++)
            rdchk("pair mode", 8'hF4 + 8'(k), 1'b0,
                  {mode_m[8*p+2*k+1], mode_m[8*p+2*k]});
      end
      check_pins();
      modes(1'b0);
      ext_val <= $random(seed);
      repeat (4) @(posedge core_clk_i);
      for (int p = 0; p < 4; p++)
      begin
         v = (p == 2) ? 8'h3F : 8'hFF;
         rdchk("pin read", 8'h80 + 8'(16*p), 1'b0, ext_val[8*p+:8], v);
         rdchk("rmw read", 8'h80 + 8'(16*p), 1'b1, 8'hFF, v);
      end
      ext_val <= 32'hFFFF_FFFF;
      $display("test pin modes done");
      wr(port_wake_pkg::ADDR_IRQ_ENABLE, 8'h81);
      wr(port_wake_pkg::ADDR_POWER_CONTROL, 8'h01);
      wait_sig("idle entry", 0, 1'b1, 4);
      pin(26, 1'b0);
      wait_sig("idle wake", 0, 1'b0, 8);
      check("isr entry", 32'(irq_ext0_o), 32'h1);
      // isr keeps the port index it found
      rdchk("saved index", 8'hF3, 1'b0, 8'h03);
      pin(26, 1'b1);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE, 8'h01);
      wr(port_wake_pkg::ADDR_POWER_CONTROL, 8'h01);
      pin(26, 1'b0);
      stay("no global", 0, 1'b1, 12);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE, 8'h81);
      wait_sig("late global", 0, 1'b0, 8);
      pin(26, 1'b1);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE, 8'h80);
      wr(port_wake_pkg::ADDR_POWER_CONTROL, 8'h01);
      periph_irq_i <= 8'($random(seed)) | 8'h01;
      wait_sig("periph wake", 0, 1'b0, 8);
      check("periph irq", 32'(irq_periph_o), 32'h1);
      periph_irq_i <= 8'h00;
      $display("test idle done");
      for (int ea = 0; ea < 2; ea++)
      begin
         wr(port_wake_pkg::ADDR_IRQ_ENABLE, ea ? 8'h84 : 8'h04);
         wr(port_wake_pkg::ADDR_POWER_CONTROL, 8'h02);
         wait_sig("halt entry", 1, 1'b1, 4);
         pin(27, 1'b0);
         wait_sig("halt wake", 1, 1'b0, 12);
         check("warm hold", 32'(cpu_hold_o), 32'h1);
         wait_sig("warm end", 0, 1'b0, HOLD + 3);
         check("post mask", 32'(irq_ext1_o), 32'h0);
         // the slot after the halt write is a no-op
         retire();
         check("post irq", 32'(irq_ext1_o), 32'(ea));
         pin(27, 1'b1);
         wait_sig("irq gone", 2, 1'b0, 6);
      end
      wr(port_wake_pkg::ADDR_PORT_INDEX, 8'h00);
      wr(port_wake_pkg::ADDR_PAIR_MODE_A, 8'h19);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE, 8'h00);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE2, 8'h00);
      wr(port_wake_pkg::ADDR_POWER_CONTROL, 8'h02);
      wait_sig("halt entry", 1, 1'b1, 4);
      pin(1, 1'b0);
      stay("plain pin", 1, 1'b1, 10);
      pin(0, 1'b0);
      wait_sig("change wake", 1, 1'b0, 10);
      wait_sig("change warm", 0, 1'b0, HOLD + 3);
      retire();
      check("pc irq off", 32'(irq_pin_change_o), 32'h0);
      rdchk("pc flag", port_wake_pkg::ADDR_IRQ_ENABLE2, 0, 8'h01);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE, 8'h80);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE2, 8'h03);
      check("pc irq on", 32'(irq_pin_change_o), 32'h1);
      wr(port_wake_pkg::ADDR_IRQ_ENABLE2, 8'h02);
      check("pc cleared", 32'(irq_pin_change_o), 32'h0);
      $display("test halt done");
      finish_test();
   end
endmodule
`default_nettype wire
